// ===== verilog/swap_xor_defs.vh
// Constants for the swap / xor / direction-load execute block.
// Assumes a 14-bit instruction word and an 8-bit data path.
`ifndef SWAP_XOR_DEFS_VH
`define SWAP_XOR_DEFS_VH
// ****************************************
// Opcode patterns
// ****************************************
`define OPC_SWAP_HI 6'h0E
`define OPC_XORF_HI 6'h06
`define OPC_XORL_HI 6'h3A
`define OPC_DIRL_HI 11'h00C
// ****************************************
// Field positions
// ****************************************
`define DEST_BIT 7
`define DIR_SEL_MIN 3'h5
`define DIR_SEL_MAX 3'h7
// ****************************************
// Direction register file addresses, and reset values for direction and W
// ****************************************
`define DIR_ADDR_5 7'h05
`define DIR_ADDR_6 7'h06
`define DIR_ADDR_7 7'h07
`define DIR_RESET 8'hFF
`define W_RESET 8'h00
`endif

// ===== verilog/swap_xor_dirload_exec.v
// Decode and execute of nibble swap, xor literal, xor file, direction load.
// Assumes the core presents one instruction per cycle with the addressed
// file value already read; results are written back by the core.
// How it works
// - Pattern 00 1110 d fffffff swaps nibbles of the addressed value.
// - Nibble swap changes no flags, one word, one cycle.
// - Pattern 11 1010 kkkkkkkk puts W xor literal into W, updates Z.
// - Pattern 00 0110 d fffffff computes W xor file, routed by d.
// - File xor touches only Z, one word, one cycle.
// - Pattern 00 0000 0110 0fff loads W into direction register 5..7.
// - Direction load kept for compatibility; no flags change.
// - Direction registers are also plain addressed registers.
// - Destination 0 writes W, destination 1 writes the file register.
`timescale 1ns/10ps
`include "swap_xor_defs.vh"

module swap_xor_dirload_exec (
   input wire CLK_SYS,
   input wire SRST,
   input wire INSTR_VALID,
   input wire [13:0] INSTR,
   input wire [7:0] FILE_RDATA,
   input wire FILE_WR_EN,
   input wire [6:0] FILE_WR_ADDR,
   input wire [7:0] FILE_WR_DATA,
   input wire [6:0] DIR_RD_ADDR,
   output reg [7:0] W_OUT,
   output reg ZERO_OUT,
   output reg Z_UPDATE,
   output reg F_WR,
   output reg [6:0] F_WR_ADDR,
   output reg [7:0] F_WR_DATA,
   output reg ILLEGAL,
   output reg [7:0] DIR_RDATA,
   output reg [23:0] DIR_ALL
);

// ****************************************
// Decode helpers
// ****************************************
// One bit per direction register; shared by the plain write and the read
function [2:0] addr_hit;
   input [6:0] a;
   begin
      addr_hit = 3'h0;
      if (a == `DIR_ADDR_5) begin
         addr_hit = 3'h1;
      end else if (a == `DIR_ADDR_6) begin
         addr_hit = 3'h2;
      end else if (a == `DIR_ADDR_7) begin
         addr_hit = 3'h4;
      end
   end
endfunction

// Same one-hot form for the load selector; 0..4 select nothing
function [2:0] sel_hit;
   input [2:0] s;
   begin
      sel_hit = 3'h0;
      if (s == `DIR_SEL_MIN) begin
         sel_hit = 3'h1;
      end else if (s == `DIR_SEL_MAX) begin
         sel_hit = 3'h4;
      end else if ((s > `DIR_SEL_MIN) && (s < `DIR_SEL_MAX)) begin
         sel_hit = 3'h2;
      end
   end
endfunction

// ****************************************
// Instruction decode
// ****************************************
wire op_swap;
wire op_xorl;
wire op_xorf;
wire op_dirl;
wire dest_file;
wire [2:0] dir_sel;
wire [2:0] sel_onehot;
wire dir_ok;
wire [2:0] load_hit;
wire [2:0] wr_hit;
wire [2:0] rd_hit;
wire [23:0] nxt_dir;
reg [7:0] w_ff;
reg [7:0] nxt_w;
reg [7:0] nxt_result;
reg [23:0] dir_ff;

assign op_swap = INSTR_VALID && (INSTR[13:8] == `OPC_SWAP_HI);
assign op_xorl = INSTR_VALID && (INSTR[13:8] == `OPC_XORL_HI);
assign op_xorf = INSTR_VALID && (INSTR[13:8] == `OPC_XORF_HI);
assign op_dirl = INSTR_VALID && (INSTR[13:3] == `OPC_DIRL_HI);
assign dest_file = INSTR[`DEST_BIT];
assign dir_sel = INSTR[2:0];
assign sel_onehot = sel_hit(dir_sel);
// Selector values 0..4 name no direction register; flagged, not executed
assign dir_ok = |sel_onehot;
assign load_hit = op_dirl ? sel_onehot : 3'h0;
// Plain writes reach the direction registers like any file register
assign wr_hit = FILE_WR_EN ? addr_hit(FILE_WR_ADDR) : 3'h0;
assign rd_hit = addr_hit(DIR_RD_ADDR);

// ****************************************
// Result datapath
// ****************************************
always @* begin
   nxt_result = 8'h00;
   if (op_swap) begin
      nxt_result = {FILE_RDATA[3:0], FILE_RDATA[7:4]};
   end else if (op_xorf) begin
      nxt_result = w_ff ^ FILE_RDATA;
   end else if (op_xorl) begin
      nxt_result = w_ff ^ INSTR[7:0];
   end
end

// ****************************************
// Accumulator
// ****************************************
// W_OUT mirrors w_ff so the port comes straight from a flip-flop
always @* begin
   nxt_w = w_ff;
   if ((op_swap || op_xorf) && !dest_file) begin
      nxt_w = nxt_result;
   end else if (op_xorl) begin
      nxt_w = nxt_result;
   end
end

always @(posedge CLK_SYS) begin
   if (SRST) begin
      w_ff <= `W_RESET;
      W_OUT <= `W_RESET;
   end else begin
      w_ff <= nxt_w;
      W_OUT <= nxt_w;
   end
end

// ****************************************
// Zero flag
// ****************************************
// Swap and direction load leave the flag alone
always @(posedge CLK_SYS) begin
   if (SRST) begin
      ZERO_OUT <= 1'b0;
      Z_UPDATE <= 1'b0;
   end else begin
      Z_UPDATE <= op_xorl || op_xorf;
      if (op_xorl || op_xorf) begin
         ZERO_OUT <= (nxt_result == 8'h00);
      end
   end
end

// ****************************************
// File write-back
// ****************************************
// The core loops F_WR back; direction registers see it only that way
always @(posedge CLK_SYS) begin
   if (SRST) begin
      F_WR <= 1'b0;
      F_WR_ADDR <= 7'h00;
      F_WR_DATA <= 8'h00;
   end else begin
      F_WR <= (op_swap || op_xorf) && dest_file;
      if ((op_swap || op_xorf) && dest_file) begin
         F_WR_ADDR <= INSTR[6:0];
         F_WR_DATA <= nxt_result;
      end
   end
end

// ****************************************
// Refused selector
// ****************************************
always @(posedge CLK_SYS) begin
   if (SRST) begin
      ILLEGAL <= 1'b0;
   end else begin
      ILLEGAL <= op_dirl && !dir_ok;
   end
end

// ****************************************
// Direction registers
// ****************************************
// Instruction load wins over a same-cycle plain write to the same register
genvar gi;
generate
   for (gi = 0; gi < 3; gi = gi + 1) begin : g_dir
      assign nxt_dir[gi*8 +: 8] = load_hit[gi] ? w_ff :
                                  wr_hit[gi] ? FILE_WR_DATA :
                                  dir_ff[gi*8 +: 8];
   end
endgenerate

always @(posedge CLK_SYS) begin
   if (SRST) begin
      dir_ff <= {3{`DIR_RESET}};
   end else begin
      dir_ff <= nxt_dir;
   end
end

// ****************************************
// Read-back
// ****************************************
always @(posedge CLK_SYS) begin
   if (SRST) begin
      DIR_RDATA <= 8'h00;
      DIR_ALL <= {3{`DIR_RESET}};
   end else begin
      DIR_ALL <= dir_ff;
      if (rd_hit[0]) begin
         DIR_RDATA <= dir_ff[7:0];
      end else if (rd_hit[1]) begin
         DIR_RDATA <= dir_ff[15:8];
      end else if (rd_hit[2]) begin
         DIR_RDATA <= dir_ff[23:16];
      end else begin
         DIR_RDATA <= 8'h00;
      end
   end
end

endmodule // swap_xor_dirload_exec

// ===== tb/swap_xor_checker.sv
// Assertions for the swap / xor / direction-load block.
// Assumes it is bound to that block and sees only its ports.
`timescale 1ns/10ps
module swap_xor_checker (
   input wire CLK_SYS,
   input wire SRST,
   input wire INSTR_VALID,
   input wire [13:0] INSTR,
   input wire [7:0] FILE_RDATA,
   input wire [7:0] W_OUT,
   input wire ZERO_OUT,
   input wire Z_UPDATE,
   input wire F_WR,
   input wire [6:0] F_WR_ADDR,
   input wire [7:0] F_WR_DATA,
   input wire ILLEGAL,
   input wire [23:0] DIR_ALL
);
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (SRST);
   wire xl = INSTR_VALID && INSTR[13:8] == 6'h3A;
   wire xf = INSTR_VALID && INSTR[13:8] == 6'h06;
   wire sw = INSTR_VALID && INSTR[13:8] == 6'h0E;
   wire dl = INSTR_VALID && INSTR[13:3] == 11'h00C;
   wire [7:0] x = W_OUT ^ FILE_RDATA;
   a_xorl_result: assert property (xl |=> Z_UPDATE &&
      W_OUT == ($past(W_OUT) ^ $past(INSTR[7:0]))) else $error("xorl");
   a_xorl_zero: assert property (xl |=>
      ZERO_OUT == (W_OUT == 8'h00)) else $error("zero flag");
   a_xorf_wreg: assert property (xf && !INSTR[7] |=>
      W_OUT == $past(x) && !F_WR && Z_UPDATE) else $error("xorf to w");
   a_xorf_file: assert property (xf && INSTR[7] |=> F_WR &&
      F_WR_DATA == $past(x) && F_WR_ADDR == $past(INSTR[6:0]) &&
      $stable(W_OUT)) else $error("xorf to file");
   a_swap_file: assert property (sw && INSTR[7] |=> F_WR &&
      F_WR_DATA == {$past(FILE_RDATA[3:0]), $past(FILE_RDATA[7:4])})
      else $error("swap");
   a_swap_flags: assert property (sw |=>
      !Z_UPDATE && $stable(ZERO_OUT)) else $error("swap flags");
   a_dirl_bad: assert property (dl && INSTR[2:0] < 3'h5 |=>
      ILLEGAL && $stable(W_OUT)) else $error("bad selector");
   a_dirl_six: assert property (dl && INSTR[2:0] == 3'h6 |=>
      !Z_UPDATE ##1 DIR_ALL[15:8] == $past(W_OUT, 2)) else $error("dir");
   a_dirl_quiet: assert property (dl |=> !Z_UPDATE && !F_WR &&
      $stable(ZERO_OUT) && $stable(W_OUT)) else $error("dir flags");
   a_dirl_five: assert property (dl && INSTR[2:0] == 3'h5 |->
      ##2 DIR_ALL[7:0] == $past(W_OUT, 2)) else $error("dir five");
   a_swap_wreg: assert property (sw && !INSTR[7] |=> !F_WR &&
      W_OUT == {$past(FILE_RDATA[3:0]), $past(FILE_RDATA[7:4])})
      else $error("swap to w");
   a_xorf_zero: assert property (xf |=>
      ZERO_OUT == ($past(x) == 8'h00)) else $error("xorf zero");
endmodule // swap_xor_checker
bind swap_xor_dirload_exec swap_xor_checker chk (.CLK_SYS, .SRST,
   .INSTR_VALID, .INSTR, .FILE_RDATA, .W_OUT, .ZERO_OUT, .Z_UPDATE,
   .F_WR, .F_WR_ADDR, .F_WR_DATA, .ILLEGAL, .DIR_ALL);

// ===== tb/swap_xor_dirload_exec_bench.sv
// Self-checking bench for the swap / xor / direction-load block.
// Assumes the block and its checker are compiled first.
`timescale 1ns/10ps
`define CHK(a,b) begin cmp_count++; if ((a) !== (b)) begin n_errors++; \
   $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module swap_xor_dirload_exec_bench;
   reg clk = 0, srst = 1, iv = 0, fwe = 0;
   reg [13:0] ins = 0;
   reg [7:0] frd = 0, fwd = 0;
   reg [6:0] fwa = 0, dra = 0;
   wire [7:0] w, fd, drd;
   wire z, zu, fw, ill;
   wire [6:0] fa;
   wire [23:0] da;
   integer n_errors = 0, cmp_count = 0, s;
   swap_xor_dirload_exec dut (.CLK_SYS(clk), .SRST(srst), .INSTR_VALID(iv),
      .INSTR(ins), .FILE_RDATA(frd), .FILE_WR_EN(fwe), .FILE_WR_ADDR(fwa),
      .FILE_WR_DATA(fwd), .DIR_RD_ADDR(dra), .W_OUT(w), .ZERO_OUT(z),
      .Z_UPDATE(zu), .F_WR(fw), .F_WR_ADDR(fa), .F_WR_DATA(fd),
      .ILLEGAL(ill), .DIR_RDATA(drd), .DIR_ALL(da));
   initial forever #2.5 clk = ~clk;
   // Outputs are read one step after the taking edge, once settled;
   // a free edge before each word keeps iv from changing twice in a step
   task ex(input [13:0] i, input [7:0] f);
      begin
         @(posedge clk);
         #1;
         ins = i;
         frd = f;
         iv = 1;
         @(posedge clk);
         #1;
         iv = 0;
      end
   endtask
   task t_xorl;
      begin
         ex(14'h3AB5, 8'h00);
         `CHK(w, 8'hB5)
         ex(14'h3AAF, 8'h00);
         `CHK({w, zu, z}, {8'h1A, 2'b10})
         ex(14'h3A1A, 8'h00);
         `CHK(z, 1'b1)
      end
   endtask
   task t_xorf;
      begin
         ex(14'h0690, 8'hAF);
         `CHK({fw, fa, fd, w}, {8'h90, 16'hAF00})
         ex(14'h3AB5, 8'h00);
         ex(14'h0610, 8'hB5);
         `CHK({fw, w, zu, z}, {9'h000, 2'b11})
      end
   endtask
   task t_swap;
      begin
         ex(14'h0E85, 8'hA5);
         `CHK({fw, fa, fd}, {8'h85, 8'h5A})
         `CHK({zu, z}, 2'b01)
         ex(14'h0E05, 8'hA5);
         `CHK({fw, w}, {1'b0, 8'h5A})
      end
   endtask
   task t_dirl;
      begin
         for (s = 5; s < 8; s = s + 1) begin
            ex({11'h00C, s[2:0]}, 8'h00);
            `CHK({zu, ill}, 2'b00)
         end
         ex(14'h3A66, 8'h00);
         ex(14'h0064, 8'h00);
         `CHK({ill, w}, {1'b1, 8'h3C})
         @(posedge clk);
         #1;
         `CHK(da, 24'h5A5A5A)
         fwa = 7'h06;
         fwd = 8'hC3;
         fwe = 1;
         @(posedge clk);
         #1;
         fwe = 0;
         dra = 7'h06;
         repeat (2) @(posedge clk);
         #1;
         `CHK({drd, da[15:8]}, 16'hC3C3)
         // Load and plain write to one register in the same cycle
         @(posedge clk);
         #1;
         ins = 14'h0065;
         iv = 1;
         fwa = 7'h05;
         fwd = 8'h11;
         fwe = 1;
         @(posedge clk);
         #1;
         iv = 0;
         fwe = 0;
         dra = 7'h05;
         @(posedge clk);
         #1;
         `CHK(drd, 8'h3C)
         dra = 7'h10;
         @(posedge clk);
         #1;
         `CHK(drd, 8'h00)
      end
   endtask
   // Mid-run reset, then the first word after release must see W at zero
   task t_reset;
      begin
         @(posedge clk);
         #1;
         srst = 1;
         @(posedge clk);
         #1;
         `CHK({w, z, zu, fw, ill, drd}, 20'h00000)
         `CHK(da, 24'hFFFFFF)
         srst = 0;
         ex(14'h3A5C, 8'h00);
         `CHK({w, zu, z}, {8'h5C, 2'b10})
      end
   endtask
   task wrap_up;
      begin
         $display("errors %0d compares %0d", n_errors, cmp_count);
         if (n_errors == 0 && cmp_count > 0)
            $display("Simulation passed");
         else
            $display("Simulation failed");
         $finish;
      end
   endtask
   // Tests need about 46 cycles; the limit leaves ample slack
   initial begin
      #5000;
      n_errors++;
      wrap_up;
   end
   initial begin
      repeat (8) @(posedge clk);
      #1;
      srst = 0;
      t_xorl;
      t_xorf;
      t_swap;
      t_dirl;
      t_reset;
      wrap_up;
   end
endmodule // swap_xor_dirload_exec_bench
